/* common/rahc_defs.svh */
`ifndef RAHC_DEFS_SVH
`define RAHC_DEFS_SVH

// ---------------------------------------------------------------
// parameter numbers and sub-indices
// ---------------------------------------------------------------
`define RAHC_PAR_ROTARY 16'h03ee
`define RAHC_PAR_METHOD 16'h041a
`define RAHC_PAR_OFFSET 16'h041b
`define RAHC_SUB_MODE 8'h00
`define RAHC_SUB_LOWER 8'h01
`define RAHC_SUB_UPPER 8'h02

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RAHC_RST_MODE 8'h00
`define RAHC_RST_LOWER 32'h80000000
`define RAHC_RST_UPPER 32'h7fffffff
`define RAHC_RST_OFFSET 32'h00000000
`define RAHC_RST_METHOD 8'h22

// ---------------------------------------------------------------
// rotary modes
// ---------------------------------------------------------------
`define RAHC_ROT_OFF 8'h00
`define RAHC_ROT_SHORT 8'h01
`define RAHC_ROT_FROM_SET 8'h02
`define RAHC_ROT_POS 8'h03
`define RAHC_ROT_NEG 8'h04

// ---------------------------------------------------------------
// homing method codes, two's complement
// ---------------------------------------------------------------
`define RAHC_M_STOP_POS 8'hee
`define RAHC_M_STOP_NEG 8'hef
`define RAHC_M_STOP_IDX_N 8'hfe
`define RAHC_M_STOP_IDX_P 8'hff
`define RAHC_M_LIM_IDX_N 8'h01
`define RAHC_M_LIM_IDX_P 8'h02
`define RAHC_M_REF_IDX_P 8'h07
`define RAHC_M_REF_IDX_N 8'h0b
`define RAHC_M_LIM_NEG 8'h11
`define RAHC_M_LIM_POS 8'h12
`define RAHC_M_REF_POS 8'h17
`define RAHC_M_REF_NEG 8'h1b
`define RAHC_M_IDX_NEG 8'h20
`define RAHC_M_IDX_POS 8'h21
`define RAHC_M_HERE 8'h22

// ---------------------------------------------------------------
// pin input indices
// ---------------------------------------------------------------
`define RAHC_IN_LIM_NEG 0
`define RAHC_IN_LIM_POS 1
`define RAHC_IN_REF 2
`define RAHC_IN_IDX 3

`endif

/* common/rahc_pkg.sv */
`include "rahc_defs.svh"

package rahc_pkg;

  typedef enum logic [2:0] {H_IDLE, H_SEEK, H_BACK, H_INDEX, H_LATCH} rahc_hstate_t;
  typedef enum logic [2:0] {SRC_NONE, SRC_STOP, SRC_LIM, SRC_REF, SRC_IDX} rahc_src_t;

  typedef struct packed {
    logic ok;
    rahc_src_t src;
    logic dir_pos;
    logic use_idx;
    logic idx_pos;
  } rahc_dec_t;

  typedef struct packed {
    rahc_hstate_t st;
    rahc_dec_t dec;
    logic [7:0] rot_mode;
    logic [31:0] lower;
    logic [31:0] upper;
    logic [31:0] offset;
    logic [7:0] method;
    logic [31:0] zero;
    logic [15:0] base;
    logic [3:0][2:0] sy;
    logic [3:0] filt;
    logic [3:0] prev;
    logic dir;
    logic en;
    logic crawl;
    logic busy;
    logic done;
    logic err;
    logic valid;
    logic [1:0] rot_dir;
    logic [31:0] rdata;
    logic ack;
    logic perr;
  } rahc_top_st_t;

  typedef struct packed {
    logic [31:0] result;
  } rahc_wrap_st_t;

  function automatic rahc_dec_t rahc_decode(input logic [7:0] m);
    rahc_dec_t d;
    d = '{ok: 1'b1, src: SRC_NONE, dir_pos: 1'b0, use_idx: 1'b0, idx_pos: 1'b0};
    case (m)
      `RAHC_M_STOP_POS: begin d.src = SRC_STOP; d.dir_pos = 1'b1; end
      `RAHC_M_STOP_NEG: d.src = SRC_STOP;
      `RAHC_M_STOP_IDX_N: begin d.src = SRC_STOP; d.dir_pos = 1'b1; d.use_idx = 1'b1; end
      `RAHC_M_STOP_IDX_P: begin d.src = SRC_STOP; d.use_idx = 1'b1; d.idx_pos = 1'b1; end
      `RAHC_M_LIM_IDX_N: begin d.src = SRC_LIM; d.use_idx = 1'b1; end
      `RAHC_M_LIM_IDX_P: begin d.src = SRC_LIM; d.dir_pos = 1'b1; d.use_idx = 1'b1; d.idx_pos = 1'b1; end
      `RAHC_M_REF_IDX_P: begin d.src = SRC_REF; d.dir_pos = 1'b1; d.use_idx = 1'b1; end
      `RAHC_M_REF_IDX_N: begin d.src = SRC_REF; d.use_idx = 1'b1; d.idx_pos = 1'b1; end
      `RAHC_M_LIM_NEG: d.src = SRC_LIM;
      `RAHC_M_LIM_POS: begin d.src = SRC_LIM; d.dir_pos = 1'b1; end
      `RAHC_M_REF_POS: begin d.src = SRC_REF; d.dir_pos = 1'b1; end
      `RAHC_M_REF_NEG: d.src = SRC_REF;
      `RAHC_M_IDX_NEG: d.src = SRC_IDX;
      `RAHC_M_IDX_POS: begin d.src = SRC_IDX; d.dir_pos = 1'b1; end
      `RAHC_M_HERE: d.src = SRC_NONE;
      default: d.ok = 1'b0;
    endcase
    return d;
  endfunction

endpackage

/* common/rahc_wrap_if.sv */
`timescale 1ns/1ps

interface rahc_wrap_if;
  logic en;
  logic [31:0] lower;
  logic [31:0] upper;
  logic [31:0] value;
  logic [31:0] result;

  modport core (input en, input lower, input upper, input value, output result);
  modport user (output en, output lower, output upper, output value, input result);
endinterface

/* design/rahc_top.sv */
`timescale 1ns/1ps
`include "rahc_defs.svh"

// Overview of operation
// - in rotary mode setpoints and actual values fold into lower..upper, ends coincide.
// - setpoint folding acts only in position mode.
// - fixed positive rotation never blocks negative setpoints.
// - rotary mode 0 off,1 shortest,2 from set,3 positive,4 negative; resets 0.
// - rotary limits are signed 32-bit; lower defaults to most negative value.
// - method code picks reference source, move order and index evaluation.
// - zero lies at reference point plus signed home offset, default 0; method 34 ignores the offset.
// - -18 seeks stop positive, -17 negative; stop at 50% i2t rise.
// - optional torque threshold declares the stop instead.
// - plain stop homing uses the stop itself as home.
// - -2/-1 find stop, then first index pulse negative/positive.
// - 18/17 seek limit positive/negative, then crawl back.
// - limit homing without index homes at limit falling edge.
// - methods 1/2 home at first index pulse negative/positive from the limit.
// - 23/27 seek reference switch, crawl back, home at its falling edge.
// - reaching the limit while seeking the reference switch reverses direction.
// - methods 7/11 home at first index pulse from the reference switch.
// - 32/33 home at first index pulse searching negative/positive.
// - method 34 makes the present position zero without motion.
module rahc_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // parameter access from the fieldbus controller
  input wire logic par_wr_in,
  input wire logic par_rd_in,
  input wire logic [15:0] par_num_in,
  input wire logic [7:0] par_sub_in,
  input wire logic [31:0] par_wdata_in,
  output logic [31:0] par_rdata_out,
  output logic par_ack_out,
  output logic par_err_out,
  // position path
  input wire logic pos_mode_in,
  input wire logic set_dir_pos_in,
  input wire logic [31:0] pos_raw_in,
  input wire logic [31:0] pos_set_in,
  output logic [31:0] pos_act_out,
  output logic [31:0] pos_set_out,
  output logic [1:0] rot_dir_out,
  // homing control and sensors
  input wire logic home_start_in,
  input wire logic lim_neg_in,
  input wire logic lim_pos_in,
  input wire logic ref_sw_in,
  input wire logic index_in,
  input wire logic stop_torque_sel_in,
  input wire logic [15:0] i2t_in,
  input wire logic [15:0] torque_in,
  input wire logic [15:0] torque_cmp_in,
  // homing status and motion request
  output logic drive_en_out,
  output logic drive_dir_pos_out,
  output logic drive_crawl_out,
  output logic home_busy_out,
  output logic home_done_out,
  output logic home_err_out,
  output logic home_valid_out
);
  import rahc_pkg::*;

  rahc_top_st_t s;
  rahc_top_st_t next_s;
  rahc_dec_t dec_now;
  logic [3:0] pins;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [16:0] stop_lvl;
  logic [15:0] torque_abs;
  logic stop_hit;
  logic lim_ahead;
  logic lim_behind_fall;
  logic [31:0] delta;
  logic [31:0] span;
  logic [31:0] delta_abs;

  rahc_wrap_if set_w ();
  rahc_wrap_if act_w ();

  // ---------------------------------------------------------------
  // rotary folding
  // ---------------------------------------------------------------
  assign set_w.en = (s.rot_mode != `RAHC_ROT_OFF) && pos_mode_in;
  assign set_w.lower = s.lower;
  assign set_w.upper = s.upper;
  assign set_w.value = pos_set_in;
  assign act_w.en = (s.rot_mode != `RAHC_ROT_OFF);
  assign act_w.lower = s.lower;
  assign act_w.upper = s.upper;
  assign act_w.value = pos_raw_in - s.zero;

  rahc_wrap u_set (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .w(set_w.core)
  );

  rahc_wrap u_act (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .w(act_w.core)
  );

  // ---------------------------------------------------------------
  // sensor events and stop detection
  // ---------------------------------------------------------------
  assign pins = {index_in, ref_sw_in, lim_pos_in, lim_neg_in};
  assign rise = s.filt & ~s.prev;
  assign fall = ~s.filt & s.prev;
  assign stop_lvl = {1'b0, s.base} + {2'b00, s.base[15:1]};
  assign torque_abs = torque_in[15] ? 16'(-torque_in) : torque_in;
  assign stop_hit = stop_torque_sel_in ? (torque_abs >= torque_cmp_in)
                                       : ({1'b0, i2t_in} >= stop_lvl);
  assign lim_ahead = s.dir ? s.filt[`RAHC_IN_LIM_POS] : s.filt[`RAHC_IN_LIM_NEG];
  // crawling back reverses the seek, so the switch left behind is the opposite one
  assign lim_behind_fall = s.dir ? fall[`RAHC_IN_LIM_NEG] : fall[`RAHC_IN_LIM_POS];
  assign dec_now = rahc_decode(s.method);
  assign span = s.upper - s.lower;
  assign delta = set_w.result - act_w.result;
  assign delta_abs = delta[31] ? -delta : delta;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.prev = s.filt;
    // only the agreeing second and third stages move the filtered level
    for (int i = 0; i < 4; i++) begin
      next_s.sy[i] = {s.sy[i][1:0], pins[i]};
      if (s.sy[i][1] == s.sy[i][2]) begin
        next_s.filt[i] = s.sy[i][2];
      end
    end

    // parameter writes and reads
    if (par_wr_in) begin
      next_s.ack = 1'b1;
      next_s.perr = 1'b0;
      if (par_num_in == `RAHC_PAR_ROTARY && par_sub_in == `RAHC_SUB_MODE) begin
        if (par_wdata_in <= 32'(`RAHC_ROT_NEG)) begin
          next_s.rot_mode = par_wdata_in[7:0];
        end else begin
          next_s.perr = 1'b1;
        end
      end else if (par_num_in == `RAHC_PAR_ROTARY && par_sub_in == `RAHC_SUB_LOWER) begin
        next_s.lower = par_wdata_in;
      end else if (par_num_in == `RAHC_PAR_ROTARY && par_sub_in == `RAHC_SUB_UPPER) begin
        next_s.upper = par_wdata_in;
      end else if (par_num_in == `RAHC_PAR_METHOD) begin
        next_s.method = par_wdata_in[7:0];
      end else if (par_num_in == `RAHC_PAR_OFFSET) begin
        next_s.offset = par_wdata_in;
      end else begin
        next_s.perr = 1'b1;
      end
    end else if (par_rd_in) begin
      next_s.ack = 1'b1;
      next_s.perr = 1'b0;
      next_s.rdata = '0;
      if (par_num_in == `RAHC_PAR_ROTARY && par_sub_in == `RAHC_SUB_MODE) begin
        next_s.rdata = {24'h000000, s.rot_mode};
      end else if (par_num_in == `RAHC_PAR_ROTARY && par_sub_in == `RAHC_SUB_LOWER) begin
        next_s.rdata = s.lower;
      end else if (par_num_in == `RAHC_PAR_ROTARY && par_sub_in == `RAHC_SUB_UPPER) begin
        next_s.rdata = s.upper;
      end else if (par_num_in == `RAHC_PAR_METHOD) begin
        next_s.rdata = {{24{s.method[7]}}, s.method};
      end else if (par_num_in == `RAHC_PAR_OFFSET) begin
        next_s.rdata = s.offset;
      end else begin
        next_s.perr = 1'b1;
      end
    end

    // preferred direction of travel in position mode
    case (s.rot_mode)
      `RAHC_ROT_SHORT: begin
        if ({delta_abs[30:0], 1'b0} > span) begin
          next_s.rot_dir = delta[31] ? 2'h1 : 2'h2;
        end else begin
          next_s.rot_dir = delta[31] ? 2'h2 : 2'h1;
        end
      end
      `RAHC_ROT_FROM_SET: next_s.rot_dir = set_dir_pos_in ? 2'h1 : 2'h2;
      `RAHC_ROT_POS: next_s.rot_dir = 2'h1;
      `RAHC_ROT_NEG: next_s.rot_dir = 2'h2;
      default: next_s.rot_dir = 2'h0;
    endcase

    // homing sequencer
    case (s.st)
      H_IDLE: begin
        next_s.en = 1'b0;
        if (home_start_in) begin
          if (!dec_now.ok) begin
            next_s.err = 1'b1;
          end else begin
            next_s.err = 1'b0;
            next_s.done = 1'b0;
            next_s.dec = dec_now;
            next_s.dir = dec_now.dir_pos;
            next_s.crawl = 1'b0;
            next_s.base = i2t_in;
            next_s.busy = 1'b1;
            if (dec_now.src == SRC_NONE) begin
              next_s.st = H_LATCH;
            end else begin
              next_s.st = H_SEEK;
              next_s.en = 1'b1;
            end
          end
        end
      end
      H_SEEK: begin
        case (s.dec.src)
          SRC_STOP: begin
            if (stop_hit) begin
              if (s.dec.use_idx) begin
                next_s.st = H_INDEX;
                next_s.dir = s.dec.idx_pos;
                next_s.crawl = 1'b1;
              end else begin
                next_s.st = H_LATCH;
              end
            end
          end
          SRC_LIM: begin
            if (lim_ahead) begin
              next_s.st = H_BACK;
              next_s.dir = ~s.dir;
              next_s.crawl = 1'b1;
            end
          end
          SRC_REF: begin
            if (s.filt[`RAHC_IN_REF]) begin
              next_s.st = H_BACK;
              next_s.dir = ~s.dir;
              next_s.crawl = 1'b1;
            end else if (lim_ahead) begin
              next_s.dir = ~s.dir;
            end
          end
          SRC_IDX: begin
            if (rise[`RAHC_IN_IDX]) begin
              next_s.st = H_LATCH;
            end
          end
          default: next_s.st = H_LATCH;
        endcase
      end
      H_BACK: begin
        if ((s.dec.src == SRC_LIM) ? lim_behind_fall : fall[`RAHC_IN_REF]) begin
          if (s.dec.use_idx) begin
            next_s.st = H_INDEX;
            next_s.dir = s.dec.idx_pos;
          end else begin
            next_s.st = H_LATCH;
          end
        end
      end
      H_INDEX: begin
        if (rise[`RAHC_IN_IDX]) begin
          next_s.st = H_LATCH;
        end
      end
      H_LATCH: begin
        next_s.en = 1'b0;
        next_s.crawl = 1'b0;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.valid = 1'b1;
        next_s.st = H_IDLE;
        if (s.dec.src == SRC_NONE) begin
          next_s.zero = pos_raw_in;
        end else begin
          next_s.zero = pos_raw_in + s.offset;
        end
      end
      default: next_s.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
      s.st <= H_IDLE;
      s.rot_mode <= `RAHC_RST_MODE;
      s.lower <= `RAHC_RST_LOWER;
      s.upper <= `RAHC_RST_UPPER;
      s.offset <= `RAHC_RST_OFFSET;
      s.method <= `RAHC_RST_METHOD;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign par_rdata_out = s.rdata;
  assign par_ack_out = s.ack;
  assign par_err_out = s.perr;
  assign pos_act_out = act_w.result;
  assign pos_set_out = set_w.result;
  assign rot_dir_out = s.rot_dir;
  assign drive_en_out = s.en;
  assign drive_dir_pos_out = s.dir;
  assign drive_crawl_out = s.crawl;
  assign home_busy_out = s.busy;
  assign home_done_out = s.done;
  assign home_err_out = s.err;
  assign home_valid_out = s.valid;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in || !ce_in);

  property p_refuse;
    (s.st == H_IDLE && home_start_in && !dec_now.ok) |=> (home_err_out && s.st == H_IDLE && $stable(s.zero));
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad method not refused");

  property p_mode_legal;
    s.rot_mode <= `RAHC_ROT_NEG;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("rotary mode out of range");

  property p_stop_dir;
    (s.st == H_SEEK && s.dec.src == SRC_STOP) |-> (drive_dir_pos_out == s.dec.dir_pos && drive_en_out);
  endproperty
  a_stop_dir: assert property (p_stop_dir) else $error("stop seek in wrong direction");

  property p_lim_home;
    (s.st == H_BACK && s.dec.src == SRC_LIM && !s.dec.use_idx && lim_behind_fall)
      |=> s.st == H_LATCH ##1 (home_done_out && s.zero == $past(pos_raw_in) + s.offset);
  endproperty
  a_lim_home: assert property (p_lim_home) else $error("limit falling edge not homed");

  property p_ref_reverse;
    (s.st == H_SEEK && s.dec.src == SRC_REF && !s.filt[`RAHC_IN_REF] && lim_ahead)
      |=> (drive_dir_pos_out != $past(drive_dir_pos_out) && s.st == H_SEEK);
  endproperty
  a_ref_reverse: assert property (p_ref_reverse) else $error("no reversal at limit");

  property p_idx_home;
    (s.st == H_SEEK && s.dec.src == SRC_IDX && rise[`RAHC_IN_IDX]) |=> ##1 (home_done_out && !home_busy_out);
  endproperty
  a_idx_home: assert property (p_idx_home) else $error("index pulse not homed");

  property p_here;
    (s.st == H_IDLE && home_start_in && s.method == `RAHC_M_HERE)
      |=> (!drive_en_out && s.st == H_LATCH) ##1 (s.zero == $past(pos_raw_in) && home_done_out);
  endproperty
  a_here: assert property (p_here) else $error("current position not made zero");

  property p_back_crawl;
    (s.st == H_BACK || s.st == H_INDEX) |-> (drive_crawl_out && drive_en_out);
  endproperty
  a_back_crawl: assert property (p_back_crawl) else $error("return not at crawl speed");

  property p_set_pos_only;
    !pos_mode_in |=> (pos_set_out == $past(pos_set_in));
  endproperty
  a_set_pos_only: assert property (p_set_pos_only) else $error("setpoint folded outside position mode");

endmodule

/* design/rahc_wrap.sv */
`timescale 1ns/1ps

module rahc_wrap (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // fold request
  rahc_wrap_if.core w
);
  import rahc_pkg::*;

  rahc_wrap_st_t s;
  rahc_wrap_st_t next_s;
  logic [31:0] span;

  // ---------------------------------------------------------------
  // one-step fold
  // ---------------------------------------------------------------
  // limitation: one fold per cycle, so input must lie within one span of the range.
  // modulo arithmetic keeps the full 32-bit default range correct as well.
  always_comb begin
    span = w.upper - w.lower;
    next_s = s;
    if (!w.en) begin
      next_s.result = w.value;
    end else if ($signed(w.value) >= $signed(w.upper)) begin
      next_s.result = w.value - span;
    end else if ($signed(w.value) < $signed(w.lower)) begin
      next_s.result = w.value + span;
    end else begin
      next_s.result = w.value;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign w.result = s.result;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_in_range_kept;
    @(posedge clk_in) disable iff (!rst_b_in || !ce_in)
    (w.en && $signed(w.value) >= $signed(w.lower) && $signed(w.value) < $signed(w.upper))
      |=> (w.result == $past(w.value));
  endproperty
  a_in_range_kept: assert property (p_in_range_kept) else $error("in-range value altered");

  property p_off_passes;
    @(posedge clk_in) disable iff (!rst_b_in || !ce_in)
    !w.en |=> (w.result == $past(w.value));
  endproperty
  a_off_passes: assert property (p_off_passes) else $error("disabled wrap altered value");

endmodule

/* sim/rahc_fb_ctrl.sv */
`timescale 1ns/1ps

module rahc_fb_ctrl (
  // clock
  input wire logic clk_in,
  // answer from the drive
  input wire logic [31:0] rdata_in,
  input wire logic ack_in,
  input wire logic err_in,
  // parameter request
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] num_out,
  output logic [7:0] sub_out,
  output logic [31:0] wdata_out
);
  logic [31:0] q;
  logic e;

  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    num_out = 16'h0000;
    sub_out = 8'h00;
    wdata_out = 32'h00000000;
  end

  // released number and data lines show inverted values so stale values never pass; sub-index keeps its value
  task automatic acc(input logic w, input logic [15:0] n, input logic [7:0] s, input logic [31:0] d);
    @(posedge clk_in);
    wr_out <= w;
    rd_out <= !w;
    num_out <= n;
    sub_out <= s;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    num_out <= ~n;
    wdata_out <= ~d;
    // ack stands one cycle only: take the answer while it stands
    #1;
    q = rdata_in;
    e = err_in | !ack_in;
  endtask
endmodule

/* sim/test_rotary_axis_and_homing_control.sv */
`timescale 1ns/1ps
`include "rahc_defs.svh"
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin n_fail++; $display("BAD t=%0t got %h exp %h", $time, g, x); end end

module test_rotary_axis_and_homing_control;
  logic clk_in, rst_b_in, ce_in, par_wr_in, par_rd_in, par_ack_out, par_err_out;
  logic [15:0] par_num_in, i2t_in, torque_in, torque_cmp_in;
  logic [7:0] par_sub_in;
  logic [31:0] par_wdata_in, par_rdata_out, pos_raw_in, pos_set_in, pos_act_out, pos_set_out;
  logic [1:0] rot_dir_out;
  logic pos_mode_in, set_dir_pos_in, home_start_in, lim_neg_in, lim_pos_in, ref_sw_in, index_in;
  logic stop_torque_sel_in, drive_en_out, drive_dir_pos_out, drive_crawl_out;
  logic home_busy_out, home_done_out, home_err_out, home_valid_out;
  int n_fail = 0;
  int num_checks = 0;

  rahc_top rahc_top_i (.clk_in, .rst_b_in, .ce_in, .par_wr_in, .par_rd_in, .par_num_in, .par_sub_in,
    .par_wdata_in, .par_rdata_out, .par_ack_out, .par_err_out, .pos_mode_in, .set_dir_pos_in,
    .pos_raw_in, .pos_set_in, .pos_act_out, .pos_set_out, .rot_dir_out, .home_start_in, .lim_neg_in,
    .lim_pos_in, .ref_sw_in, .index_in, .stop_torque_sel_in, .i2t_in, .torque_in, .torque_cmp_in,
    .drive_en_out, .drive_dir_pos_out, .drive_crawl_out, .home_busy_out, .home_done_out,
    .home_err_out, .home_valid_out);

  rahc_fb_ctrl rahc_fb_ctrl_i (.clk_in, .rdata_in(par_rdata_out), .ack_in(par_ack_out),
    .err_in(par_err_out), .wr_out(par_wr_in), .rd_out(par_rd_in), .num_out(par_num_in),
    .sub_out(par_sub_in), .wdata_out(par_wdata_in));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [15:0] n, input logic [7:0] s, input logic [31:0] d);
    rahc_fb_ctrl_i.acc(1'b1, n, s, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic go(input logic [7:0] m);
    wr(`RAHC_PAR_METHOD, 8'h00, {24'h000000, m});
    @(posedge clk_in);
    home_start_in <= 1'b1;
    @(posedge clk_in);
    home_start_in <= 1'b0;
    tick(1);
  endtask

  // pins pass a 3-stage synchroniser, so waits are bounded generously
  task automatic wait_done();
    for (int i = 0; i < 40 && home_done_out !== 1'b1; i++) tick(1);
    `CHK(home_done_out, 1'b1)
    `CHK(home_busy_out, 1'b0)
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rahc_fb_ctrl_i.acc(1'b0, `RAHC_PAR_ROTARY, `RAHC_SUB_MODE, 32'h0);
    `CHK(rahc_fb_ctrl_i.q, 32'h00000000)
    rahc_fb_ctrl_i.acc(1'b0, `RAHC_PAR_ROTARY, `RAHC_SUB_LOWER, 32'h0);
    `CHK(rahc_fb_ctrl_i.q, 32'h80000000)
    rahc_fb_ctrl_i.acc(1'b0, `RAHC_PAR_OFFSET, 8'h00, 32'h0);
    `CHK(rahc_fb_ctrl_i.q, 32'h00000000)
    wr(`RAHC_PAR_ROTARY, `RAHC_SUB_MODE, 32'h5);
    `CHK(rahc_fb_ctrl_i.e, 1'b1)
    wr(16'h0001, 8'h00, 32'h1);
    `CHK(rahc_fb_ctrl_i.e, 1'b1)
    $display("test regs done");
  endtask

  task automatic t_here();
    pos_raw_in <= 32'h00001234;
    go(8'h22);
    wait_done();
    tick(2);
    `CHK(pos_act_out, 32'h00000000)
    `CHK(home_valid_out, 1'b1)
    $display("test here done");
  endtask

  task automatic t_index();
    wr(`RAHC_PAR_OFFSET, 8'h00, 32'h10);
    go(8'h21);
    `CHK({drive_en_out, drive_dir_pos_out, drive_crawl_out}, 3'b110)
    index_in <= 1'b1;
    tick(2);
    index_in <= 1'b0;
    wait_done();
    tick(2);
    `CHK(pos_act_out, 32'hfffffff0)
    $display("test index done");
  endtask

  task automatic t_limit();
    go(8'h12);
    `CHK({drive_dir_pos_out, drive_crawl_out}, 2'b10)
    lim_pos_in <= 1'b1;
    tick(8);
    `CHK({drive_dir_pos_out, drive_crawl_out}, 2'b01)
    `CHK(home_done_out, 1'b0)
    lim_pos_in <= 1'b0;
    wait_done();
    $display("test limit done");
  endtask

  task automatic t_stop_bad();
    stop_torque_sel_in <= 1'b1;
    torque_cmp_in <= 16'h0064;
    go(8'hee);
    `CHK(drive_dir_pos_out, 1'b1)
    torque_in <= 16'h00c8;
    wait_done();
    torque_in <= 16'h0000;
    stop_torque_sel_in <= 1'b0;
    i2t_in <= 16'h0064;
    go(8'hff);
    `CHK({drive_dir_pos_out, drive_crawl_out}, 2'b00)
    i2t_in <= 16'h0096;
    tick(2);
    `CHK({drive_dir_pos_out, drive_crawl_out}, 2'b11)
    index_in <= 1'b1;
    tick(2);
    index_in <= 1'b0;
    wait_done();
    // moved raw position shows whether the refused start touched zero
    pos_raw_in <= 32'h00001254;
    go(8'h05);
    tick(1);
    `CHK({home_err_out, home_busy_out}, 2'b10)
    `CHK(pos_act_out, 32'h00000010)
    $display("test stop and refused done");
  endtask

  task automatic t_rotary();
    wr(`RAHC_PAR_ROTARY, `RAHC_SUB_LOWER, 32'h0);
    wr(`RAHC_PAR_ROTARY, `RAHC_SUB_UPPER, 32'h64);
    `CHK(rahc_fb_ctrl_i.e, 1'b0)
    wr(`RAHC_PAR_ROTARY, `RAHC_SUB_MODE, 32'h1);
    pos_mode_in <= 1'b1;
    pos_set_in <= 32'h96;
    tick(3);
    `CHK(pos_set_out, 32'h32)
    pos_mode_in <= 1'b0;
    tick(3);
    `CHK(pos_set_out, 32'h96)
    wr(`RAHC_PAR_ROTARY, `RAHC_SUB_MODE, 32'h3);
    pos_mode_in <= 1'b1;
    pos_set_in <= 32'h10;
    tick(3);
    `CHK(pos_set_out, 32'h10)
    `CHK(rot_dir_out, 2'h1)
    $display("test rotary done");
  endtask

  task automatic t_ref();
    go(8'h17);
    lim_pos_in <= 1'b1;
    tick(6);
    `CHK({drive_dir_pos_out, drive_crawl_out}, 2'b00)
    lim_pos_in <= 1'b0;
    ref_sw_in <= 1'b1;
    tick(6);
    `CHK({drive_dir_pos_out, drive_crawl_out}, 2'b11)
    ref_sw_in <= 1'b0;
    wait_done();
    $display("test ref done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // whole run needs well under two hundred cycles
  initial begin
    #20000;
    n_fail++;
    close_out();
  end

  initial begin
    {rst_b_in, pos_mode_in, set_dir_pos_in, home_start_in, lim_neg_in} = '0;
    {lim_pos_in, ref_sw_in, index_in, stop_torque_sel_in} = '0;
    {i2t_in, torque_in, torque_cmp_in} = '0;
    ce_in = 1'b1;
    pos_raw_in = 32'h0;
    pos_set_in = 32'h0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_here();
    t_index();
    t_limit();
    t_ref();
    t_stop_bad();
    t_rotary();
    close_out();
  end
endmodule
